// [pus_pkg.sv]
// Overview of operation
// - Start sequence on selected external trigger
// - Cycle order: forward, stop, reverse, stop
// - Sequence repeats cycle count, default ten
// - Trigger removal never cuts a sequence short
// - Source: none, six inputs, eleven command bits
// - Unassigned source by default blocks starting
// - Forward ramps use own times, default 3 s
// - Reverse ramps use own times, default 3 s
// - Forward and reverse durations, default 10 s
// - Stop phase time settable, default 0 s
// - Status not configured or inactive when idle
// - Waiting for run conditions reads pending
// - Executing sequence reads running, flag set
package pus_pkg;

	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 16;
	localparam int SPEED_W = 10;
	localparam int TIME_W  = 9;
	localparam int CNT_W   = 7;
	localparam int SEL_W   = 5;
	localparam int MS_W    = 19;
	localparam int NUM_DI  = 6;
	localparam int NUM_CMD = 11;
	localparam int IRQ_W   = 3;

	localparam logic [ADDR_W-1:0] REG_TRIG_SEL  = 4'h0;
	localparam logic [ADDR_W-1:0] REG_CMD_WORD  = 4'h1;
	localparam logic [ADDR_W-1:0] REG_FWD_SPEED = 4'h2;
	localparam logic [ADDR_W-1:0] REG_REV_SPEED = 4'h3;
	localparam logic [ADDR_W-1:0] REG_FWD_ACC   = 4'h4;
	localparam logic [ADDR_W-1:0] REG_FWD_DEC   = 4'h5;
	localparam logic [ADDR_W-1:0] REG_REV_ACC   = 4'h6;
	localparam logic [ADDR_W-1:0] REG_REV_DEC   = 4'h7;
	localparam logic [ADDR_W-1:0] REG_FWD_DUR   = 4'h8;
	localparam logic [ADDR_W-1:0] REG_REV_DUR   = 4'h9;
	localparam logic [ADDR_W-1:0] REG_PAUSE_DUR = 4'ha;
	localparam logic [ADDR_W-1:0] REG_CYCLE_NB  = 4'hb;
	localparam logic [ADDR_W-1:0] REG_STATUS    = 4'hc;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 4'hd;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK  = 4'he;

	localparam logic [SEL_W-1:0]   RST_TRIG_SEL = 5'h00;
	localparam logic [SPEED_W-1:0] RST_SPEED    = 10'h000;
	localparam logic [TIME_W-1:0]  RST_RAMP_S   = 9'h003;
	localparam logic [TIME_W-1:0]  RST_PHASE_S  = 9'h00a;
	localparam logic [TIME_W-1:0]  RST_PAUSE_S  = 9'h000;
	localparam logic [CNT_W-1:0]   RST_CYCLE_NB = 7'h0a;

	localparam logic [SPEED_W-1:0] MAX_SPEED    = 10'h257;
	localparam logic [TIME_W-1:0]  MAX_TIME_S   = 9'h12c;
	localparam logic [CNT_W-1:0]   MIN_CYCLE_NB = 7'h01;
	localparam logic [CNT_W-1:0]   MAX_CYCLE_NB = 7'h64;

	localparam logic [SEL_W-1:0] SEL_NONE      = 5'h00;
	localparam logic [SEL_W-1:0] SEL_DI_FIRST  = 5'h01;
	localparam logic [SEL_W-1:0] SEL_DI_LAST   = 5'h06;
	localparam logic [SEL_W-1:0] SEL_CMD_FIRST = 5'h07;
	localparam logic [SEL_W-1:0] SEL_CMD_LAST  = 5'h11;

	localparam logic [1:0] STAT_NOT_CFG  = 2'h0;
	localparam logic [1:0] STAT_INACTIVE = 2'h1;
	localparam logic [1:0] STAT_PENDING  = 2'h2;
	localparam logic [1:0] STAT_RUNNING  = 2'h3;

	localparam int STS_PEND_BIT = 2;
	localparam int STS_RUN_BIT  = 3;
	localparam int STS_REV_BIT  = 4;
	localparam int STS_CYC_LSB  = 8;

	localparam int IRQ_STARTED = 0;
	localparam int IRQ_DONE    = 1;
	localparam int IRQ_ABORT   = 2;

	localparam int CLK_FREQ_HZ    = 40_000_000;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES    = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;
	localparam logic [MS_W-1:0] MS_PER_S = 19'h003e8;

	typedef enum logic [3:0] {
		ST_IDLE, ST_PEND, ST_FWD_ACC, ST_FWD_HOLD, ST_FWD_DEC,
		ST_PAUSE_A, ST_REV_ACC, ST_REV_HOLD, ST_REV_DEC, ST_PAUSE_B
	} pus_state_type;

	function automatic logic [MS_W-1:0] to_ms(input logic [TIME_W-1:0] secs);
		to_ms = MS_W'({10'h000, secs} * MS_PER_S);
	endfunction

endpackage

// [pus_ramp_if.sv]
interface pus_ramp_if;
	logic                          tick;
	logic                          start;
	logic                          up;
	logic [pus_pkg::SPEED_W-1:0]   target;
	logic [pus_pkg::TIME_W-1:0]    time_s;
	logic [pus_pkg::SPEED_W-1:0]   speed;
	logic                          busy;

	modport ctl (output tick, output start, output up, output target, output time_s, input speed, input busy);
	modport ramp (input tick, input start, input up, input target, input time_s, output speed, output busy);
endinterface

// [pus_ramp.sv]
module pus_ramp (
	// Clock and reset
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	// Control
	pus_ramp_if.ramp   rif
);

	logic [pus_pkg::SPEED_W-1:0] speed_q, speed_d;
	logic [pus_pkg::SPEED_W-1:0] slope_q, slope_d;
	logic [pus_pkg::MS_W-1:0]    acc_q, acc_d;
	logic [pus_pkg::MS_W-1:0]    span_q, span_d;
	logic [pus_pkg::MS_W-1:0]    sum;
	logic                        busy_q, busy_d;
	logic                        up_q, up_d;

	// Bresenham stepping: span is at least 1000 ms and slope at most 599, so one step per tick is enough
	always_comb begin
		speed_d = speed_q;
		slope_d = slope_q;
		acc_d   = acc_q;
		span_d  = span_q;
		busy_d  = busy_q;
		up_d    = up_q;
		sum     = acc_q + {9'h000, slope_q};
		if (rif.start) begin
			up_d    = rif.up;
			slope_d = rif.target;
			span_d  = pus_pkg::to_ms(rif.time_s);
			acc_d   = '0;
			busy_d  = (rif.time_s != '0);
			if (rif.time_s == '0) begin
				speed_d = rif.up ? rif.target : '0;
			end
		end else if (busy_q && rif.tick) begin
			if (up_q ? (speed_q >= slope_q) : (speed_q == '0)) begin
				busy_d = 1'b0;
			end else if (sum >= span_q) begin
				acc_d   = sum - span_q;
				speed_d = up_q ? speed_q + 10'h001 : speed_q - 10'h001;
			end else begin
				acc_d = sum;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			speed_q <= '0;
			slope_q <= '0;
			acc_q   <= '0;
			span_q  <= '0;
			busy_q  <= 1'b0;
			up_q    <= 1'b0;
		end else begin
			speed_q <= speed_d;
			slope_q <= slope_d;
			acc_q   <= acc_d;
			span_q  <= span_d;
			busy_q  <= busy_d;
			up_q    <= up_d;
		end
	end

	assign rif.speed = speed_q;
	assign rif.busy  = busy_q;

	AST_RAMP_STEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!rif.start |=> (speed_q == $past(speed_q) || speed_q == $past(speed_q) + 10'h001
			|| speed_q + 10'h001 == $past(speed_q)))
		else $error("Ramp moved by more than one step");

	AST_RAMP_MONO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(busy_q && !rif.start) |=> (up_q ? speed_q >= $past(speed_q) : speed_q <= $past(speed_q)))
		else $error("Ramp moved against its direction");

endmodule

// [pus_top.sv]
module pus_top #(
	parameter int unsigned TICK_CYCLES = pus_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                          REF_CLK_I,
	input  wire logic                          RESET_N_I,
	// Register port
	input  wire logic [pus_pkg::ADDR_W-1:0]    ADDR_I,
	input  wire logic [pus_pkg::DATA_W-1:0]    WR_DATA_I,
	input  wire logic                          WR_EN_I,
	input  wire logic                          RD_EN_I,
	output logic      [pus_pkg::DATA_W-1:0]    RD_DATA_O,
	// Drive run and trigger side
	input  wire logic [pus_pkg::NUM_DI-1:0]    DI_I,
	input  wire logic                          RUN_CMD_I,
	input  wire logic                          AWAKE_I,
	input  wire logic                          MOTOR_STOPPED_I,
	// Motor reference side
	output logic      [pus_pkg::SPEED_W-1:0]   SPEED_REF_O,
	output logic                               DIR_REV_O,
	output logic                               PENDING_O,
	output logic                               RUNNING_O,
	output logic                               IRQ_O
);

	pus_ramp_if rif ();

	pus_ramp u_ramp (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RESET_N_I),
		.rif     (rif)
	);

	// Digital inputs are pins: two flops before use
	logic [pus_pkg::NUM_DI-1:0] di_s1_q, di_s2_q;
	always_ff @(posedge REF_CLK_I) begin
		if (!RESET_N_I) begin
			di_s1_q <= '0;
			di_s2_q <= '0;
		end else begin
			di_s1_q <= DI_I;
			di_s2_q <= di_s1_q;
		end
	end

	// Millisecond tick
	logic [15:0] div_q, div_d;
	logic        tick_q, tick_d;
	always_comb begin
		tick_d = (div_q == 16'(TICK_CYCLES - 1));
		div_d  = tick_d ? '0 : div_q + 16'h0001;
	end
	always_ff @(posedge REF_CLK_I) begin
		if (!RESET_N_I) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	// Register file
	logic [pus_pkg::SEL_W-1:0]   sel_q, sel_d;
	logic [pus_pkg::NUM_CMD-1:0] cmd_q, cmd_d;
	logic [pus_pkg::SPEED_W-1:0] fwd_spd_q, fwd_spd_d, rev_spd_q, rev_spd_d;
	logic [pus_pkg::TIME_W-1:0]  fwd_acc_q, fwd_acc_d, fwd_dec_q, fwd_dec_d;
	logic [pus_pkg::TIME_W-1:0]  rev_acc_q, rev_acc_d, rev_dec_q, rev_dec_d;
	logic [pus_pkg::TIME_W-1:0]  fwd_dur_q, fwd_dur_d, rev_dur_q, rev_dur_d, pause_q, pause_d;
	logic [pus_pkg::CNT_W-1:0]   cyc_nb_q, cyc_nb_d;
	logic [pus_pkg::IRQ_W-1:0]   irq_st_q, irq_st_d, irq_mk_q, irq_mk_d, irq_ev;
	logic [pus_pkg::DATA_W-1:0]  rd_q, rd_d;
	logic [pus_pkg::TIME_W-1:0]  wr_time;
	logic [pus_pkg::SPEED_W-1:0] wr_spd;
	logic [pus_pkg::CNT_W-1:0]   wr_cnt;
	logic [1:0]                  stat_code;

	// Sequencer state
	pus_pkg::pus_state_type      st_q, st_d;
	logic [pus_pkg::MS_W-1:0]    tmr_q, tmr_d;
	logic [pus_pkg::CNT_W-1:0]   done_q, done_d;
	logic                        trig_prev_q, trig_lvl, trig_rise, configured, start_ok, timer_up;
	logic [pus_pkg::SEL_W-1:0]   idx;

	always_comb begin
		wr_time  = (WR_DATA_I[8:0] > pus_pkg::MAX_TIME_S) ? pus_pkg::MAX_TIME_S : WR_DATA_I[8:0];
		wr_spd   = (WR_DATA_I[9:0] > pus_pkg::MAX_SPEED) ? pus_pkg::MAX_SPEED : WR_DATA_I[9:0];
		wr_cnt   = (WR_DATA_I[6:0] < pus_pkg::MIN_CYCLE_NB) ? pus_pkg::MIN_CYCLE_NB :
			(WR_DATA_I[6:0] > pus_pkg::MAX_CYCLE_NB) ? pus_pkg::MAX_CYCLE_NB : WR_DATA_I[6:0];
		sel_d     = sel_q;
		cmd_d     = cmd_q;
		fwd_spd_d = fwd_spd_q;
		rev_spd_d = rev_spd_q;
		fwd_acc_d = fwd_acc_q;
		fwd_dec_d = fwd_dec_q;
		rev_acc_d = rev_acc_q;
		rev_dec_d = rev_dec_q;
		fwd_dur_d = fwd_dur_q;
		rev_dur_d = rev_dur_q;
		pause_d   = pause_q;
		cyc_nb_d  = cyc_nb_q;
		irq_mk_d  = irq_mk_q;
		irq_st_d  = irq_st_q;
		if (WR_EN_I) begin
			unique case (ADDR_I)
				pus_pkg::REG_TRIG_SEL:  sel_d     = WR_DATA_I[4:0];
				pus_pkg::REG_CMD_WORD:  cmd_d     = WR_DATA_I[10:0];
				pus_pkg::REG_FWD_SPEED: fwd_spd_d = wr_spd;
				pus_pkg::REG_REV_SPEED: rev_spd_d = wr_spd;
				pus_pkg::REG_FWD_ACC:   fwd_acc_d = wr_time;
				pus_pkg::REG_FWD_DEC:   fwd_dec_d = wr_time;
				pus_pkg::REG_REV_ACC:   rev_acc_d = wr_time;
				pus_pkg::REG_REV_DEC:   rev_dec_d = wr_time;
				pus_pkg::REG_FWD_DUR:   fwd_dur_d = wr_time;
				pus_pkg::REG_REV_DUR:   rev_dur_d = wr_time;
				pus_pkg::REG_PAUSE_DUR: pause_d   = wr_time;
				pus_pkg::REG_CYCLE_NB:  cyc_nb_d  = wr_cnt;
				pus_pkg::REG_IRQ_STAT:  irq_st_d  = irq_st_q & ~WR_DATA_I[2:0];
				pus_pkg::REG_IRQ_MASK:  irq_mk_d  = WR_DATA_I[2:0];
				default: ;
			endcase
		end
		// Set wins over a same-cycle clear
		irq_st_d = irq_st_d | irq_ev;
	end

	// Trigger source decode
	always_comb begin
		configured = (sel_q >= pus_pkg::SEL_DI_FIRST) && (sel_q <= pus_pkg::SEL_CMD_LAST);
		idx        = '0;
		trig_lvl   = 1'b0;
		if (sel_q >= pus_pkg::SEL_DI_FIRST && sel_q <= pus_pkg::SEL_DI_LAST) begin
			idx      = sel_q - pus_pkg::SEL_DI_FIRST;
			trig_lvl = di_s2_q[idx[2:0]];
		end else if (sel_q >= pus_pkg::SEL_CMD_FIRST && sel_q <= pus_pkg::SEL_CMD_LAST) begin
			idx      = sel_q - pus_pkg::SEL_CMD_FIRST;
			trig_lvl = cmd_q[idx[3:0]];
		end
		trig_rise = configured && trig_lvl && !trig_prev_q;
		start_ok  = RUN_CMD_I && AWAKE_I && MOTOR_STOPPED_I;
	end

	// Sequencer
	always_comb begin
		st_d       = st_q;
		tmr_d      = (tick_q && tmr_q != '1) ? tmr_q + 19'h00001 : tmr_q;
		done_d     = done_q;
		irq_ev     = '0;
		rif.tick   = tick_q;
		rif.start  = 1'b0;
		rif.up     = 1'b1;
		rif.target = fwd_spd_q;
		rif.time_s = fwd_acc_q;
		timer_up   = 1'b0;
		unique case (st_q)
			pus_pkg::ST_IDLE, pus_pkg::ST_PEND: begin
				done_d = '0;
				if (st_q == pus_pkg::ST_PEND && !configured) begin
					st_d = pus_pkg::ST_IDLE;
				end else if (trig_rise || st_q == pus_pkg::ST_PEND) begin
					st_d = start_ok ? pus_pkg::ST_FWD_ACC : pus_pkg::ST_PEND;
					rif.start = start_ok;
					irq_ev[pus_pkg::IRQ_STARTED] = start_ok;
				end
			end
			pus_pkg::ST_FWD_ACC, pus_pkg::ST_REV_ACC: begin
				tmr_d = '0;
				if (!rif.busy) begin
					st_d = (st_q == pus_pkg::ST_FWD_ACC) ? pus_pkg::ST_FWD_HOLD : pus_pkg::ST_REV_HOLD;
				end
			end
			pus_pkg::ST_FWD_HOLD: begin
				timer_up = tmr_q >= pus_pkg::to_ms(fwd_dur_q);
				if (timer_up) begin
					st_d       = pus_pkg::ST_FWD_DEC;
					rif.start  = 1'b1;
					rif.up     = 1'b0;
					rif.time_s = fwd_dec_q;
				end
			end
			pus_pkg::ST_REV_HOLD: begin
				timer_up = tmr_q >= pus_pkg::to_ms(rev_dur_q);
				if (timer_up) begin
					st_d       = pus_pkg::ST_REV_DEC;
					rif.start  = 1'b1;
					rif.up     = 1'b0;
					rif.target = rev_spd_q;
					rif.time_s = rev_dec_q;
				end
			end
			pus_pkg::ST_FWD_DEC, pus_pkg::ST_REV_DEC: begin
				tmr_d = '0;
				if (!rif.busy) begin
					st_d = (st_q == pus_pkg::ST_FWD_DEC) ? pus_pkg::ST_PAUSE_A : pus_pkg::ST_PAUSE_B;
				end
			end
			pus_pkg::ST_PAUSE_A: begin
				if (tmr_q >= pus_pkg::to_ms(pause_q)) begin
					st_d       = pus_pkg::ST_REV_ACC;
					rif.start  = 1'b1;
					rif.target = rev_spd_q;
					rif.time_s = rev_acc_q;
				end
			end
			pus_pkg::ST_PAUSE_B: begin
				if (tmr_q >= pus_pkg::to_ms(pause_q)) begin
					done_d = done_q + 7'h01;
					if (done_d >= cyc_nb_q) begin
						st_d = pus_pkg::ST_IDLE;
						irq_ev[pus_pkg::IRQ_DONE] = 1'b1;
					end else begin
						st_d      = pus_pkg::ST_FWD_ACC;
						rif.start = 1'b1;
					end
				end
			end
		endcase
		// Trigger level is ignored once running; only the run command can end a sequence early
		if (st_q != pus_pkg::ST_IDLE && st_q != pus_pkg::ST_PEND && !RUN_CMD_I) begin
			st_d       = pus_pkg::ST_IDLE;
			rif.start  = 1'b1;
			rif.up     = 1'b0;
			rif.time_s = '0;
			irq_ev     = '0;
			irq_ev[pus_pkg::IRQ_ABORT] = 1'b1;
		end
	end

	// Status and read data
	always_comb begin
		if (st_d == pus_pkg::ST_PEND) begin
			stat_code = pus_pkg::STAT_PENDING;
		end else if (st_d != pus_pkg::ST_IDLE) begin
			stat_code = pus_pkg::STAT_RUNNING;
		end else begin
			stat_code = configured ? pus_pkg::STAT_INACTIVE : pus_pkg::STAT_NOT_CFG;
		end
		rd_d = '0;
		if (RD_EN_I) begin
			unique case (ADDR_I)
				pus_pkg::REG_TRIG_SEL:  rd_d = {11'h000, sel_q};
				pus_pkg::REG_CMD_WORD:  rd_d = {5'h00, cmd_q};
				pus_pkg::REG_FWD_SPEED: rd_d = {6'h00, fwd_spd_q};
				pus_pkg::REG_REV_SPEED: rd_d = {6'h00, rev_spd_q};
				pus_pkg::REG_FWD_ACC:   rd_d = {7'h00, fwd_acc_q};
				pus_pkg::REG_FWD_DEC:   rd_d = {7'h00, fwd_dec_q};
				pus_pkg::REG_REV_ACC:   rd_d = {7'h00, rev_acc_q};
				pus_pkg::REG_REV_DEC:   rd_d = {7'h00, rev_dec_q};
				pus_pkg::REG_FWD_DUR:   rd_d = {7'h00, fwd_dur_q};
				pus_pkg::REG_REV_DUR:   rd_d = {7'h00, rev_dur_q};
				pus_pkg::REG_PAUSE_DUR: rd_d = {7'h00, pause_q};
				pus_pkg::REG_CYCLE_NB:  rd_d = {9'h000, cyc_nb_q};
				pus_pkg::REG_STATUS:    rd_d = {1'b0, done_q, 3'h0, DIR_REV_O, RUNNING_O, PENDING_O, stat_code};
				pus_pkg::REG_IRQ_STAT:  rd_d = {13'h0000, irq_st_q};
				pus_pkg::REG_IRQ_MASK:  rd_d = {13'h0000, irq_mk_q};
				default:                rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!RESET_N_I) begin
			sel_q       <= pus_pkg::RST_TRIG_SEL;
			cmd_q       <= '0;
			fwd_spd_q   <= pus_pkg::RST_SPEED;
			rev_spd_q   <= pus_pkg::RST_SPEED;
			fwd_acc_q   <= pus_pkg::RST_RAMP_S;
			fwd_dec_q   <= pus_pkg::RST_RAMP_S;
			rev_acc_q   <= pus_pkg::RST_RAMP_S;
			rev_dec_q   <= pus_pkg::RST_RAMP_S;
			fwd_dur_q   <= pus_pkg::RST_PHASE_S;
			rev_dur_q   <= pus_pkg::RST_PHASE_S;
			pause_q     <= pus_pkg::RST_PAUSE_S;
			cyc_nb_q    <= pus_pkg::RST_CYCLE_NB;
			irq_st_q    <= '0;
			irq_mk_q    <= '0;
			rd_q        <= '0;
			st_q        <= pus_pkg::ST_IDLE;
			tmr_q       <= '0;
			done_q      <= '0;
			trig_prev_q <= 1'b0;
			SPEED_REF_O <= '0;
			DIR_REV_O   <= 1'b0;
			PENDING_O   <= 1'b0;
			RUNNING_O   <= 1'b0;
			IRQ_O       <= 1'b0;
		end else begin
			sel_q       <= sel_d;
			cmd_q       <= cmd_d;
			fwd_spd_q   <= fwd_spd_d;
			rev_spd_q   <= rev_spd_d;
			fwd_acc_q   <= fwd_acc_d;
			fwd_dec_q   <= fwd_dec_d;
			rev_acc_q   <= rev_acc_d;
			rev_dec_q   <= rev_dec_d;
			fwd_dur_q   <= fwd_dur_d;
			rev_dur_q   <= rev_dur_d;
			pause_q     <= pause_d;
			cyc_nb_q    <= cyc_nb_d;
			irq_st_q    <= irq_st_d;
			irq_mk_q    <= irq_mk_d;
			rd_q        <= rd_d;
			st_q        <= st_d;
			tmr_q       <= tmr_d;
			done_q      <= done_d;
			trig_prev_q <= trig_lvl;
			SPEED_REF_O <= rif.speed;
			DIR_REV_O   <= (st_d inside {pus_pkg::ST_REV_ACC, pus_pkg::ST_REV_HOLD, pus_pkg::ST_REV_DEC});
			PENDING_O   <= (st_d == pus_pkg::ST_PEND);
			RUNNING_O   <= (st_d != pus_pkg::ST_IDLE && st_d != pus_pkg::ST_PEND);
			IRQ_O       <= |(irq_st_d & irq_mk_d);
		end
	end

	assign RD_DATA_O = rd_q;

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RESET_N_I);

	sequence s_fwd_end;
		st_q == pus_pkg::ST_FWD_DEC ##1 st_q != pus_pkg::ST_FWD_DEC;
	endsequence

	AST_NO_START_UNASSIGNED: assert property (
		(st_q == pus_pkg::ST_IDLE && !configured) |=> !RUNNING_O && !PENDING_O)
		else $error("Sequence left idle with no trigger source");
	AST_START_ON_TRIGGER: assert property (
		(st_q == pus_pkg::ST_IDLE && trig_rise) |=> (PENDING_O || RUNNING_O))
		else $error("Trigger edge did not start or queue a sequence");
	AST_PAUSE_AFTER_FWD: assert property (
		s_fwd_end |-> ((st_q == pus_pkg::ST_PAUSE_A && rif.speed == '0)
			|| (st_q == pus_pkg::ST_IDLE && !$past(RUN_CMD_I))))
		else $error("Forward phase not followed by a stop");
	AST_REV_AFTER_PAUSE: assert property (
		(st_q == pus_pkg::ST_REV_ACC && $past(st_q) != pus_pkg::ST_REV_ACC) |-> $past(st_q) == pus_pkg::ST_PAUSE_A)
		else $error("Reverse phase entered out of order");
	AST_CYCLE_COUNT: assert property (
		(st_q == pus_pkg::ST_PAUSE_B && st_d == pus_pkg::ST_IDLE && RUN_CMD_I) |-> done_d == cyc_nb_q)
		else $error("Sequence ended after wrong cycle count");
	AST_KEEP_RUNNING: assert property (
		(RUNNING_O && RUN_CMD_I && st_q != pus_pkg::ST_PAUSE_B) |=> RUNNING_O)
		else $error("Sequence stopped early without loss of run command");
	AST_PENDING_FLAG: assert property (
		PENDING_O |-> (st_q == pus_pkg::ST_PEND && !$past(start_ok || !configured)))
		else $error("Pending flag wrong");
	AST_START_NEEDS_RUN: assert property (
		(st_q == pus_pkg::ST_PEND ##1 st_q == pus_pkg::ST_FWD_ACC) |-> $past(start_ok))
		else $error("Sequence started without run conditions");
	AST_STATUS_IDLE: assert property (
		(RD_EN_I && ADDR_I == pus_pkg::REG_STATUS && st_d == pus_pkg::ST_IDLE) |=> RD_DATA_O[1:0] ==
			(($past(sel_q) >= pus_pkg::SEL_DI_FIRST && $past(sel_q) <= pus_pkg::SEL_CMD_LAST) ?
			pus_pkg::STAT_INACTIVE : pus_pkg::STAT_NOT_CFG))
		else $error("Idle status code wrong");
	AST_FWD_DIR_SPEED: assert property (
		(st_q == pus_pkg::ST_FWD_HOLD) |=> (!DIR_REV_O || st_q != pus_pkg::ST_FWD_HOLD) && SPEED_REF_O <= pus_pkg::MAX_SPEED)
		else $error("Forward phase direction or speed wrong");

endmodule

// [pus_motor_model.sv]
module pus_motor_model #(
	parameter int SETTLE = 3
) (
	// Clock
	input  wire logic                        clk_i,
	// Reference from the sequencer
	input  wire logic [pus_pkg::SPEED_W-1:0] speed_i,
	// Standstill report to the drive
	output logic                             stopped_o
);
	timeunit 1ns;
	timeprecision 1ps;

	int settle_cnt = 0;

	// A real shaft coasts a while after the reference reaches zero
	always @(posedge clk_i) begin
		if (speed_i != '0)
			settle_cnt <= 0;
		else if (settle_cnt < SETTLE)
			settle_cnt <= settle_cnt + 1;
	end

	assign stopped_o = (settle_cnt >= SETTLE);
endmodule

// [pump_unclog_sequencer_test.sv]
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module pump_unclog_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk = 0, reset_n = 0, wr_en = 0, rd_en = 0, run_cmd = 0, rd_p = 0, stopped, awake = 1, mv_on = 1;
	logic [3:0] addr = '0;
	logic [15:0] wr_data = '0, rd_data;
	logic [5:0] di = '0;
	logic [9:0] speed_ref, speed_prev = '0, fs, rs;
	logic dir_rev, pending, running, irq;
	logic [15:0] rdq[$], rst_tab[16], rd_exp;
	logic [10:0] mvq[$], mv_exp;
	int failures = 0, checks = 0, cyc = 0, w, mv_n = 0, mv_t = 0;

	initial forever #12.5 ref_clk = ~ref_clk;

	pus_top #(.TICK_CYCLES(1)) u_pus_top (.REF_CLK_I(ref_clk), .RESET_N_I(reset_n), .ADDR_I(addr),
		.WR_DATA_I(wr_data), .WR_EN_I(wr_en), .RD_EN_I(rd_en), .RD_DATA_O(rd_data), .DI_I(di),
		.RUN_CMD_I(run_cmd), .AWAKE_I(awake), .MOTOR_STOPPED_I(stopped), .SPEED_REF_O(speed_ref),
		.DIR_REV_O(dir_rev), .PENDING_O(pending), .RUNNING_O(running), .IRQ_O(irq));

	pus_motor_model u_pus_motor_model (.clk_i(ref_clk), .speed_i(speed_ref), .stopped_o(stopped));

	// Watcher: read data and, while mv_on is set, each new nonzero reference are matched to the oldest note
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		// Notes are popped once, outside the macro, so a mismatch cannot eat a second note
		if (rd_p) begin
			rd_exp = rdq.pop_front();
			`CHK(rd_data, rd_exp)
		end
		rd_p <= rd_en;
		speed_prev <= speed_ref;
		// Phase to phase: one 1 s duration plus one 1 s stop, a few cycles of hand-over allowed
		if (mv_on && speed_ref !== speed_prev && speed_ref != '0) begin
			mv_exp = mvq.pop_front();
			`CHK({dir_rev, speed_ref}, mv_exp)
			if (mv_n > 0) `CHK((cyc - mv_t) inside {[2000:2008]}, 1'b1)
			mv_n <= mv_n + 1;
			mv_t <= cyc;
		end
		if (cyc == 60000) begin
			failures++;
			$display("[ERR] %0t run took too long", $time);
			results();
		end
	end

	task automatic acc(input logic w_en, input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		wr_en <= w_en;
		rd_en <= ~w_en;
		addr <= a;
		wr_data <= d;
		if (!w_en) rdq.push_back(d);
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			wr_en <= 1'b0;
			rd_en <= 1'b0;
		end
	endtask

	task automatic wait_run(input logic lvl);
		w = 0;
		while (running !== lvl && w < 20000) begin
			@(posedge ref_clk);
			w++;
		end
		`CHK(running, lvl)
	endtask

	task automatic results();
		$display("Counts: %0d checks, %0d failures", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		rst_tab = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0003, 16'h0003, 16'h0003, 16'h0003,
			16'h000a, 16'h000a, 16'h0000, 16'h000a, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		void'($urandom(32'h801a3770));
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		// Defaults, unmapped index included
		for (int i = 0; i < 16; i++) acc(1'b0, 4'(i), rst_tab[i]);
		idle(2);
		$display("test defaults done");
		// Zero ramps so each phase shows as one jump; speeds stay nonzero and within the 599 limit
		fs = 10'(1 + $urandom % 599);
		rs = 10'(1 + $urandom % 599);
		acc(1'b1, pus_pkg::REG_TRIG_SEL, 16'(pus_pkg::SEL_DI_FIRST));
		acc(1'b1, pus_pkg::REG_FWD_SPEED, 16'(fs));
		acc(1'b1, pus_pkg::REG_REV_SPEED, 16'(rs));
		for (int i = 4; i < 8; i++) acc(1'b1, 4'(i), 16'h0000);
		acc(1'b1, pus_pkg::REG_FWD_DUR, 16'h0001);
		acc(1'b1, pus_pkg::REG_REV_DUR, 16'h0001);
		acc(1'b1, pus_pkg::REG_PAUSE_DUR, 16'h0001);
		acc(1'b1, pus_pkg::REG_CYCLE_NB, 16'h0002);
		acc(1'b1, pus_pkg::REG_IRQ_MASK, 16'h0007);
		acc(1'b0, pus_pkg::REG_STATUS, 16'h0001);
		idle(1);
		repeat (2) begin
			mvq.push_back({1'b0, fs});
			mvq.push_back({1'b1, rs});
		end
		// Trigger without run order: must wait
		di <= 6'h01;
		repeat (8) @(posedge ref_clk);
		`CHK({pending, running}, 2'b10)
		run_cmd <= 1'b1;
		wait_run(1'b1);
		di <= 6'h00;
		acc(1'b0, pus_pkg::REG_STATUS, 16'h000b);
		idle(1);
		wait_run(1'b0);
		`CHK(mvq.size(), 0)
		`CHK(irq, 1'b1)
		acc(1'b0, pus_pkg::REG_IRQ_STAT, 16'h0003);
		acc(1'b1, pus_pkg::REG_IRQ_STAT, 16'h0003);
		idle(3);
		`CHK(irq, 1'b0)
		$display("test di sequence done");
		// Command bit source with a one second forward ramp, wake-up withheld at first
		mv_on <= 1'b0;
		awake <= 1'b0;
		acc(1'b1, pus_pkg::REG_TRIG_SEL, 16'(pus_pkg::SEL_CMD_LAST));
		acc(1'b1, pus_pkg::REG_CYCLE_NB, 16'h0001);
		acc(1'b1, pus_pkg::REG_FWD_ACC, 16'h0001);
		acc(1'b1, pus_pkg::REG_CMD_WORD, 16'h0400);
		idle(4);
		`CHK({pending, running}, 2'b10)
		awake <= 1'b1;
		wait_run(1'b1);
		// About a tenth of the way up the ramp; slack covers the edge alignment of the start
		repeat (100) @(posedge ref_clk);
		`CHK(speed_ref >= 10'((97 * fs) / 1000) && speed_ref <= 10'((101 * fs) / 1000), 1'b1)
		run_cmd <= 1'b0;
		repeat (4) @(posedge ref_clk);
		`CHK({running, speed_ref}, 11'h000)
		acc(1'b0, pus_pkg::REG_IRQ_STAT, 16'h0005);
		idle(3);
		$display("test command sequence done");
		results();
	end
endmodule
